/* File: pkg/sbs_params.svh */
// Constants for the status register bank: addresses, fields, reset values, timing
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// ==========================================================================
// Register addresses (7-bit frame address)
`define SBS_ADDR_DEV_INFO 7'h43
`define SBS_ADDR_CAN0_BUS 7'h44
`define SBS_ADDR_WAKE_SRC 7'h46

// ==========================================================================
// Field positions
`define SBS_DEV_PRIOR_HI 7
`define SBS_DEV_PRIOR_LO 6
`define SBS_DEV_WD_HI 3
`define SBS_DEV_WD_LO 2
`define SBS_DEV_BAD_CMD 1
`define SBS_DEV_FO_FLAG 0
`define SBS_BUS_FAULT_HI 2
`define SBS_BUS_FAULT_LO 1
`define SBS_BUS_SUPPLY_LOW 0
`define SBS_WK_CONV 7
`define SBS_WK_CAN0 5
`define SBS_WK_TIMER 4
`define SBS_WK_PIN 0

// ==========================================================================
// Reset values and frame layout
`define SBS_RESET_VAL 8'h00
`define SBS_FRAME_BITS 5'h10
`define SBS_HDR_BITS 5'h08
`define SBS_MODE_BIT 7
`define SBS_WATCHDOG_FAILURE_COUNT_MAX 2'h2

// ==========================================================================
// Timing
`define SBS_CLK_PERIOD_NS 10
`define SBS_DOM_TIMEOUT_NS 2000000
`define SBS_DOM_TIMEOUT_CYC \
  ((`SBS_DOM_TIMEOUT_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS)

`endif

/* File: pkg/sbs_pkg.sv */
// Types shared by the status register bank and its frame receiver
package sbs_pkg;
  // ==========================================================================
  // Data types
  typedef logic [7:0] sbs_byte_t;

  // Prior device state codes
  typedef enum logic [1:0] {
    SBS_PRIOR_CLEARED = 2'h0,
    SBS_PRIOR_RESTART_FAIL = 2'h1,
    SBS_PRIOR_SLEEP = 2'h2,
    SBS_PRIOR_RSVD = 2'h3
  } sbs_prior_t;

  // Channel-0 fault codes
  typedef enum logic [1:0] {
    SBS_FAULT_NONE = 2'h0,
    SBS_FAULT_TSD = 2'h1,
    SBS_FAULT_TXD_DOM = 2'h2,
    SBS_FAULT_BUS_DOM = 2'h3
  } sbs_can_fault_t;
endpackage

/* File: pkg/sbs_frame_if.sv */
// Frame results passed from the serial receiver to the register bank
`timescale 1ns/1ps
interface sbs_frame_if;
  import sbs_pkg::*;
  // ==========================================================================
  // Frame signals
  logic done;
  logic bad;
  logic clear;
  logic [6:0] addr;
  sbs_byte_t rd_data;

  modport rx (output done, output bad, output clear, output addr, input rd_data);
  modport regs (input done, input bad, input clear, input addr, output rd_data);
endinterface

/* File: verilog/sbs_spi_frame.sv */
// Serial frame receiver: 16-bit frames, LSB first, header then status byte out
`timescale 1ns/1ps
module sbs_spi_frame
  import sbs_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Frame results
  sbs_frame_if.rx fr
);
`include "sbs_params.svh"

  typedef enum logic {SBS_IDLE, SBS_SHIFT} sbs_rx_state_t;

  sbs_rx_state_t state;
  logic sclk_q;
  logic cs_q;
  logic [4:0] bit_cnt;
  logic [7:0] hdr;
  logic [7:0] out_sh;
  logic done_q;
  logic bad_q;

  // ==========================================================================
  // Edge and frame boundary decode
  wire logic sclk_rise = spi_sclk & ~sclk_q;
  wire logic sclk_fall = ~spi_sclk & sclk_q;
  wire logic frame_end = spi_cs_n & ~cs_q;
  wire logic in_hdr = bit_cnt < `SBS_HDR_BITS;
  wire logic frame_ok = bit_cnt == `SBS_FRAME_BITS;

  assign fr.done = done_q;
  assign fr.bad = bad_q;
  assign fr.clear = hdr[`SBS_MODE_BIT];
  assign fr.addr = hdr[6:0];
  assign spi_sdo_oe = state == SBS_SHIFT;

  // Pin history; inputs are already in the clock domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else if (ce) begin
      sclk_q <= spi_sclk;
      cs_q <= spi_cs_n;
    end
  end

  // Frame state and bit counter; counter saturates so overlong frames stay bad
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SBS_IDLE;
      bit_cnt <= 5'h00;
    end else if (ce) begin
      unique case (state)
        SBS_IDLE: begin
          bit_cnt <= 5'h00;
          if (!spi_cs_n) state <= SBS_SHIFT;
        end
        SBS_SHIFT: begin
          if (frame_end) state <= SBS_IDLE;
          else if (sclk_rise && bit_cnt != 5'h1F) bit_cnt <= bit_cnt + 5'h01;
        end
      endcase
    end
  end

  // Header capture on rising edges, status byte shifted on falling edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hdr <= 8'h00;
      out_sh <= 8'h00;
      spi_sdo <= 1'b0;
    end else if (ce) begin
      if (state == SBS_SHIFT && sclk_rise && in_hdr) hdr <= {spi_sdi, hdr[7:1]};
      if (state == SBS_SHIFT && sclk_fall && bit_cnt == `SBS_HDR_BITS) begin
        spi_sdo <= fr.rd_data[0];
        out_sh <= {1'b0, fr.rd_data[7:1]};
      end else if (state == SBS_SHIFT && sclk_fall && !in_hdr) begin
        spi_sdo <= out_sh[0];
        out_sh <= {1'b0, out_sh[7:1]};
      end else if (state == SBS_IDLE) begin
        spi_sdo <= 1'b0;
      end
    end
  end

  // One-cycle results at the end of each frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end else if (ce) begin
      done_q <= state == SBS_SHIFT && frame_end && frame_ok;
      bad_q <= state == SBS_SHIFT && frame_end && !frame_ok;
    end
  end

endmodule // sbs_spi_frame

/* File: verilog/sbs_status_regs.sv */
// Device, channel-0 bus and wake source status registers behind the serial port
// ==========================================================================
// Functional notes
// R1: Prior-state field held until software clears
// R2: Two-bit watchdog failure count, never three
// R3: Count self-clears on good trigger or stop; a stop with wd_stop_by_fail set keeps the count
// R4: Configurations 2/4 freeze count until good trigger
// R5: Bad frame sets flag; only clear resets
// R6: Fail-output flag set on activation, held
// R7: Channel-0 fault code: tsd, txd, bus
// R8: Supply low sets flag, disables transmitter
// R9: Txd timeout ends on high, off, wake
// R10: Bus timeout ends on recessive, wake, off
// R11: Supply low ends above threshold
// R12: Controller holds txd high before resuming
// R13: Supply comparator active only with mode bit
// R14: Converter auto mode change sets bit seven
// R15: Wake sources: bus five, timer four, pin
// R16: Fail-safe wakes set same source bits
// R17: Power-on or soft reset zeroes registers
// R18: Restart keeps bus fault, zeroes upper bits
// R19: Reserved bits read as zero
// R20: Frame mode bit set clears, else reads
// R21: Only watchdog count clears by itself
// R22: Flags sticky until cleared; set wins
`timescale 1ns/1ps
`include "sbs_params.svh"
module sbs_status_regs
  import sbs_pkg::*;
#(
  parameter int DOM_TIMEOUT_CYCLES = `SBS_DOM_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Serial port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Device mode events
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic [1:0] restart_cause,
  // Watchdog
  input wire logic config_strap_pin,
  input wire logic cfg_fail_first,
  input wire logic watchdog_failure_count_event,
  input wire logic wd_trigger_ok,
  input wire logic wd_stop,
  input wire logic wd_stop_by_fail,
  output logic fail_output_pin,
  // Channel-0 transceiver
  input wire logic can0_tsd,
  input wire logic transmit_input_ch0,
  input wire logic can0_bus_dominant,
  input wire logic can0_tx_on,
  input wire logic can0_wake_capable,
  input wire logic transceiver_mode_high_bit,
  input wire logic vcan_below_thr,
  output logic can0_tx_disable,
  // Wake and converter events
  input wire logic can_ch0_bus_wake,
  input wire logic cyclic_timer_wake,
  input wire logic wake_pin_wake,
  input wire logic converter_mode_change
);

  localparam int CW = $clog2(DOM_TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] DOM_LIMIT = CW'(DOM_TIMEOUT_CYCLES);

  sbs_frame_if fr ();

  // ==========================================================================
  // State
  sbs_prior_t prior_device_state;
  logic [1:0] watchdog_failure_count;
  logic wd_frozen;
  logic bad_cmd;
  logic fail_output_active_flag;
  sbs_can_fault_t can0_fault;
  logic transceiver_supply_low;
  logic converter_auto_switch_flag;
  logic [2:0] wake_bits;
  logic cfg_caught;
  logic freeze_mode;
  logic tsd_q;
  logic [CW-1:0] txd_cnt;
  logic [CW-1:0] bus_cnt;

  // Dominant timer step, shared by both timeout monitors
  function automatic logic [CW-1:0] next_dom_count(input logic [CW-1:0] cnt, input logic run);
    if (!run) return '0;
    else if (cnt == DOM_LIMIT) return cnt;
    else return CW'(cnt + 1'b1);
  endfunction

  // ==========================================================================
  // Frame receiver
  sbs_spi_frame u_frame (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .fr(fr)
  );

  // ==========================================================================
  // Register images and clear decode
  // Reserved positions are tied to zero in the images
  wire sbs_byte_t dev_reg = {prior_device_state, 2'h0, watchdog_failure_count,
                             bad_cmd, fail_output_active_flag}; // R19
  wire sbs_byte_t bus_reg = {5'h00, can0_fault, transceiver_supply_low}; // R19 R18
  wire sbs_byte_t wake_reg = {converter_auto_switch_flag, 1'b0, wake_bits[2:1],
                              3'h0, wake_bits[0]}; // R19
  wire logic clr_dev = fr.done && fr.clear && fr.addr == `SBS_ADDR_DEV_INFO; // R20
  wire logic clr_bus = fr.done && fr.clear && fr.addr == `SBS_ADDR_CAN0_BUS; // R20
  wire logic clr_wake = fr.done && fr.clear && fr.addr == `SBS_ADDR_WAKE_SRC; // R20
  wire sbs_byte_t rd_byte = fr.addr == `SBS_ADDR_DEV_INFO ? dev_reg :
                            fr.addr == `SBS_ADDR_CAN0_BUS ? bus_reg :
                            fr.addr == `SBS_ADDR_WAKE_SRC ? wake_reg : `SBS_RESET_VAL;
  assign fr.rd_data = rd_byte;

  // ==========================================================================
  // Watchdog failure count
  // Strap is caught on the first enabled edge after release; low selects freeze
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_caught <= 1'b0;
      freeze_mode <= 1'b0;
    end else if (ce && !cfg_caught) begin
      cfg_caught <= 1'b1;
      freeze_mode <= ~config_strap_pin;
    end
  end

  wire logic wd_accept = watchdog_failure_count_event && !(freeze_mode && wd_frozen); // R4
  wire logic wd_self_clear = wd_trigger_ok || (wd_stop && !wd_stop_by_fail); // R3 R21
  wire logic [1:0] wd_inc = watchdog_failure_count == `SBS_WATCHDOG_FAILURE_COUNT_MAX ?
                            watchdog_failure_count : watchdog_failure_count + 2'h1; // R2
  wire logic [1:0] fo_threshold = cfg_fail_first ? 2'h1 : `SBS_WATCHDOG_FAILURE_COUNT_MAX;
  wire logic fo_activate = wd_accept && wd_inc == fo_threshold;
  // A failure in the same cycle as a good trigger wins, except while the count is frozen, where the trigger clears it
  wire logic [1:0] next_wd = soft_reset ? 2'h0 : wd_accept ? wd_inc :
                             wd_self_clear ? 2'h0 : watchdog_failure_count; // R3

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_failure_count <= 2'h0;
      wd_frozen <= 1'b0;
    end else if (ce) begin
      watchdog_failure_count <= next_wd;
      if (soft_reset || wd_trigger_ok) wd_frozen <= 1'b0; // R4
      else if (freeze_mode && watchdog_failure_count_event) wd_frozen <= 1'b1; // R4
    end
  end

  // ==========================================================================
  // Device information flags; sets are applied after clears
  wire sbs_prior_t next_prior = soft_reset ? SBS_PRIOR_CLEARED :
                                restart_entry ? sbs_prior_t'(restart_cause) :
                                clr_dev ? SBS_PRIOR_CLEARED : prior_device_state; // R1 R17
  wire logic next_bad = !soft_reset && (fr.bad || (bad_cmd && !clr_dev)); // R5 R22
  wire logic next_fo = !soft_reset &&
                       (fo_activate || (fail_output_active_flag && !clr_dev)); // R6 R22

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prior_device_state <= SBS_PRIOR_CLEARED;
      bad_cmd <= 1'b0;
      fail_output_active_flag <= 1'b0;
      fail_output_pin <= 1'b0;
    end else if (ce) begin
      prior_device_state <= next_prior;
      bad_cmd <= next_bad;
      fail_output_active_flag <= next_fo;
      // Pin stays active until a soft reset; release policy lives elsewhere
      fail_output_pin <= !soft_reset && (fail_output_pin || fo_activate);
    end
  end

  // ==========================================================================
  // Channel-0 fault monitors
  // Timers restart from zero whenever their run condition drops
  wire logic txd_run = !transmit_input_ch0 && can0_tx_on && !can0_wake_capable; // R9
  wire logic bus_run = can0_bus_dominant && can0_tx_on && !can0_wake_capable; // R10
  wire logic txd_timeout = txd_cnt == DOM_LIMIT;
  wire logic bus_timeout = bus_cnt == DOM_LIMIT;
  wire logic txd_ev = txd_run && txd_cnt == DOM_LIMIT - 1'b1;
  wire logic bus_ev = bus_run && bus_cnt == DOM_LIMIT - 1'b1;
  wire logic tsd_ev = can0_tsd && !tsd_q;
  wire logic uv_active = transceiver_mode_high_bit && vcan_below_thr; // R13 R11
  // Latest event overwrites the code; bus dominant has the highest priority
  wire sbs_can_fault_t next_fault = soft_reset ? SBS_FAULT_NONE :
                                    bus_ev ? SBS_FAULT_BUS_DOM :
                                    txd_ev ? SBS_FAULT_TXD_DOM :
                                    tsd_ev ? SBS_FAULT_TSD :
                                    clr_bus ? SBS_FAULT_NONE : can0_fault; // R7
  wire logic next_supply_low = !soft_reset &&
                               (uv_active || (transceiver_supply_low && !clr_bus)); // R8 R22
  // Driver stays off while any fault lasts; re-enable timing is the controller's
  wire logic next_tx_disable = uv_active || txd_timeout || bus_timeout || can0_tsd; // R8 R12

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_cnt <= '0;
      bus_cnt <= '0;
      tsd_q <= 1'b0;
    end else if (ce) begin
      txd_cnt <= next_dom_count(txd_cnt, txd_run); // R9
      bus_cnt <= next_dom_count(bus_cnt, bus_run); // R10
      tsd_q <= can0_tsd;
    end
  end

  // Restart leaves these untouched on purpose
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      can0_fault <= SBS_FAULT_NONE;
      transceiver_supply_low <= 1'b0;
      can0_tx_disable <= 1'b0;
    end else if (ce) begin
      can0_fault <= next_fault; // R18
      transceiver_supply_low <= next_supply_low; // R18
      can0_tx_disable <= next_tx_disable; // R8
    end
  end

  // ==========================================================================
  // Wake source and converter flags
  // Fail-safe wakes arrive on the same event inputs
  wire logic [2:0] wake_set = {can_ch0_bus_wake, cyclic_timer_wake, wake_pin_wake}; // R15 R16
  wire logic [2:0] next_wake = soft_reset ? 3'h0 :
                               wake_set | (clr_wake ? 3'h0 : wake_bits); // R22
  wire logic next_conv = !soft_reset &&
                         (converter_mode_change ||
                          (converter_auto_switch_flag && !clr_wake)); // R14

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_bits <= 3'h0;
      converter_auto_switch_flag <= 1'b0;
    end else if (ce) begin
      wake_bits <= next_wake; // R15
      converter_auto_switch_flag <= next_conv; // R14
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_wd_count_max: assert property (watchdog_failure_count != 2'h3) // R2
    else $error("watchdog count reached three");
  a_wd_trigger_clear: assert property (ce && wd_trigger_ok && !watchdog_failure_count_event |=> // R3
    watchdog_failure_count == 2'h0) else $error("count not cleared by trigger");
  a_wd_freeze_hold: assert property (ce && freeze_mode && wd_frozen && !wd_trigger_ok && // R4
    !wd_stop && !soft_reset |=> $stable(watchdog_failure_count))
    else $error("frozen count moved");
  a_prior_restart: assert property (ce && restart_entry && !soft_reset |=> // R1
    prior_device_state == $past(restart_cause)) else $error("prior state not loaded");
  a_bad_cmd_set: assert property (ce && fr.bad && !soft_reset |=> bad_cmd ##1 // R5
    (bad_cmd || $past(clr_dev) || $past(soft_reset))) else $error("bad command flag lost");
  a_fo_flag_set: assert property (ce && fo_activate && !soft_reset |=> // R6
    fail_output_active_flag && fail_output_pin) else $error("fail output flag missing");
  a_txd_fault_code: assert property (ce && txd_ev && !bus_ev && !soft_reset |=> // R7
    can0_fault == SBS_FAULT_TXD_DOM) else $error("txd fault code wrong");
  a_uv_tx_off: assert property (ce && uv_active && !soft_reset |=> // R8
    can0_tx_disable && transceiver_supply_low) else $error("supply low not handled");
  a_txd_recover: assert property (ce && txd_timeout && transmit_input_ch0 |=> // R9
    !txd_timeout) else $error("txd timeout did not end");
  a_bus_recover: assert property (ce && bus_timeout && !can0_bus_dominant |=> // R10
    !bus_timeout) else $error("bus timeout did not end");
  a_uv_gate: assert property (ce && !transceiver_mode_high_bit && !clr_bus && !soft_reset |=> // R13
    transceiver_supply_low == $past(transceiver_supply_low)) else $error("comparator not gated");
  a_conv_flag: assert property (ce && converter_mode_change && !soft_reset |=> // R14
    wake_reg[`SBS_WK_CONV]) else $error("converter flag not set");
  a_wake_can0: assert property (ce && can_ch0_bus_wake && !soft_reset |=> // R15
    wake_reg[`SBS_WK_CAN0]) else $error("bus wake flag not set");
  a_soft_zero: assert property (ce && soft_reset |=> // R17
    dev_reg == `SBS_RESET_VAL && bus_reg == `SBS_RESET_VAL && wake_reg == `SBS_RESET_VAL)
    else $error("soft reset left bits set");
  a_reserved_zero: assert property (dev_reg[5:4] == 2'h0 && bus_reg[7:3] == 5'h00 && // R19
    wake_reg[6] == 1'b0 && wake_reg[3:1] == 3'h0 &&
    (fr.addr inside {`SBS_ADDR_DEV_INFO, `SBS_ADDR_CAN0_BUS, `SBS_ADDR_WAKE_SRC} ||
    rd_byte == `SBS_RESET_VAL)) else $error("reserved bit read as one");
  a_clear_dev: assert property (ce && clr_dev && !restart_entry && !soft_reset |=> // R20
    prior_device_state == SBS_PRIOR_CLEARED && !bad_cmd) else $error("clear did not act");

  c_txd_timeout: cover property (ce && txd_ev);
  c_clear_dev: cover property (ce && clr_dev && bad_cmd);
  c_bad_frame: cover property (ce && fr.bad);
  c_wake_read: cover property (fr.done && !fr.clear && fr.addr == `SBS_ADDR_WAKE_SRC);

endmodule // sbs_status_regs

/* File: dv/sbs_spi_master.sv */
// Serial master model standing in for the controller on the frame port
`timescale 1ns/1ps
module sbs_spi_master (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  logic [7:0] rx;
  logic oe_seen;

  // ==========================================================================
  // Idle levels: frame deselected, serial clock low
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end

  // Let n clock edges pass
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One frame, LSB first; four clocks a phase so sdo has settled before each rise
  task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] data);
    rx = 8'h00;
    oe_seen = 1'b0;
    tick(1);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_sdi <= word[i];
      tick(4);
      if (i >= 8) begin
        rx[i-8] = spi_sdo;
        oe_seen = spi_sdo_oe;
      end
      spi_sclk <= 1'b1;
      tick(4);
      spi_sclk <= 1'b0;
    end
    tick(4);
    spi_cs_n <= 1'b1;
    // Released data line shows no stale value
    spi_sdi <= ~spi_sdi;
    // Deselect gap plus time for a clear to land
    tick(6);
    data = rx;
  endtask
endmodule // sbs_spi_master

/* File: dv/sbs_status_regs_bench.sv */
// Self-checking bench for the status register bank
`timescale 1ns/1ps
`include "sbs_params.svh"
module sbs_status_regs_bench;
  import sbs_pkg::*;
  logic clk, reset_n, ce, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [1:0] restart_cause;
  logic config_strap_pin, cfg_fail_first, wd_stop_by_fail, fail_output_pin;
  logic can0_tsd, transmit_input_ch0, can0_bus_dominant, can0_tx_on, can0_wake_capable;
  logic transceiver_mode_high_bit, vcan_below_thr, can0_tx_disable;
  logic [8:0] ev;
  int errors, cmp_count;
  sbs_byte_t rd;

  // ==========================================================================
  // Design and controller model; event pulses share one vector to keep drivers short
  sbs_status_regs #(.DOM_TIMEOUT_CYCLES(20)) sbs_status_regs_inst (
    .clk, .reset_n, .ce, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe,
    .soft_reset(ev[4]), .restart_entry(ev[3]), .restart_cause, .config_strap_pin,
    .cfg_fail_first, .watchdog_failure_count_event(ev[0]), .wd_trigger_ok(ev[1]), .wd_stop(ev[2]),
    .wd_stop_by_fail, .fail_output_pin, .can0_tsd, .transmit_input_ch0,
    .can0_bus_dominant, .can0_tx_on, .can0_wake_capable, .transceiver_mode_high_bit,
    .vcan_below_thr, .can0_tx_disable, .can_ch0_bus_wake(ev[5]),
    .cyclic_timer_wake(ev[6]), .wake_pin_wake(ev[7]), .converter_mode_change(ev[8])
  );
  sbs_spi_master sbs_spi_master_inst (
    .clk, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe
  );

  // ==========================================================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
    sbs_spi_master_inst.frame({8'h00, 1'b0, a}, 16, rd);
    check(rd, exp);
    check({6'h00, sbs_spi_master_inst.oe_seen, spi_sdo_oe}, 8'h02);
  endtask
  task automatic clr_reg(input logic [6:0] a);
    sbs_spi_master_inst.frame({8'h00, 1'b1, a}, 16, rd);
  endtask
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Bounded wait for the transmitter disable level
  task automatic wait_dis(input logic exp);
    int n;
    for (n = 0; n < 100 && can0_tx_disable !== exp; n++) @(posedge clk);
    check({7'h0, can0_tx_disable}, {7'h0, exp});
    if (n == 100) stop_test;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: the whole run is a few thousand cycles
  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    stop_test;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {reset_n, ev, restart_cause, wd_stop_by_fail, can0_tsd} = '0;
    {ce, config_strap_pin, cfg_fail_first, transmit_input_ch0} = 4'hF;
    {can0_bus_dominant, can0_tx_on, can0_wake_capable} = 3'h2;
    {transceiver_mode_high_bit, vcan_below_thr} = 2'h2;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h00);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h00);
    rd_reg(`SBS_ADDR_WAKE_SRC, 8'h00);
    rd_reg(7'h45, 8'h00);
    // Prior state: read keeps it, clear drops it
    restart_cause <= 2'h1;
    pulse(3);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h40);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h40);
    clr_reg(`SBS_ADDR_DEV_INFO);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h00);
    restart_cause <= 2'h2;
    pulse(3);
    // Short frame is refused and flagged
    sbs_spi_master_inst.frame(16'h0043, 12, rd);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h82);
    clr_reg(`SBS_ADDR_DEV_INFO);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h00);
    // Watchdog count, fail output, self-clearing count
    pulse(0);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h05);
    check({7'h0, fail_output_pin}, 8'h01);
    pulse(1);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h01);
    pulse(0);
    pulse(2);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h01);
    clr_reg(`SBS_ADDR_DEV_INFO);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h00);
    // Every wake source and the converter flag
    for (int b = 5; b < 9; b++) pulse(b);
    rd_reg(`SBS_ADDR_WAKE_SRC, 8'hB1);
    clr_reg(`SBS_ADDR_WAKE_SRC);
    rd_reg(`SBS_ADDR_WAKE_SRC, 8'h00);
    // Transmit input stuck dominant, then released and held high
    transmit_input_ch0 <= 1'b0;
    wait_dis(1'b1);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h04);
    transmit_input_ch0 <= 1'b1;
    wait_dis(1'b0);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h04);
    // Bus stuck dominant, ended by wake capability
    can0_bus_dominant <= 1'b1;
    wait_dis(1'b1);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h06);
    can0_wake_capable <= 1'b1;
    wait_dis(1'b0);
    {can0_wake_capable, can0_bus_dominant} <= 2'h0;
    // Transmit input stuck again, ended by switching the transmitter off
    transmit_input_ch0 <= 1'b0;
    wait_dis(1'b1);
    can0_tx_on <= 1'b0;
    wait_dis(1'b0);
    {can0_tx_on, transmit_input_ch0} <= 2'h3;
    clr_reg(`SBS_ADDR_CAN0_BUS);
    // Thermal shutdown sticks past its cause and survives a restart
    can0_tsd <= 1'b1;
    repeat (3) @(posedge clk);
    can0_tsd <= 1'b0;
    restart_cause <= 2'h0;
    pulse(3);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h02);
    // Supply comparator gated by the mode bit
    {transceiver_mode_high_bit, vcan_below_thr} <= 2'h1;
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h02);
    transceiver_mode_high_bit <= 1'b1;
    wait_dis(1'b1);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h03);
    vcan_below_thr <= 1'b0;
    wait_dis(1'b0);
    // Wake pin sets its source bit; the soft reset below wipes everything
    pulse(7);
    // Low clock enable freezes state, so this event is dropped
    ce <= 1'b0;
    pulse(6);
    ce <= 1'b1;
    rd_reg(`SBS_ADDR_WAKE_SRC, 8'h01);
    pulse(4);
    check({7'h0, fail_output_pin}, 8'h00);
    rd_reg(`SBS_ADDR_CAN0_BUS, 8'h00);
    rd_reg(`SBS_ADDR_WAKE_SRC, 8'h00);
    // Second reset with the strap low selects the freezing configurations
    config_strap_pin <= 1'b0;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    pulse(0);
    pulse(0);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h05);
    pulse(1);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h01);
    // A stop caused by a watchdog failure keeps the count
    wd_stop_by_fail <= 1'b1;
    pulse(0);
    pulse(2);
    rd_reg(`SBS_ADDR_DEV_INFO, 8'h05);
    stop_test;
  end
endmodule // sbs_status_regs_bench
